/* File: pkg/mms_pkg.sv */
// mms_pkg: constants and types of the magnetometer mode sequencer.
// assumes a single 40 MHz clock domain shared by all design files.
package mms_pkg;

  // clock and timing
  localparam int CLK_HZ         = 40_000_000;
  localparam int CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int STANDBY_STATE_TIME_US   = 250;
  localparam int ACTIVE_TIME_US = 8;
  localparam int DATA_READY_FLAG_GAP_US    = 10;
  localparam int TICK_TIME_US   = 1000;
  localparam int STANDBY_STATE_CYC       = STANDBY_STATE_TIME_US * CYC_PER_US;
  localparam int TICK_CYC       = TICK_TIME_US * CYC_PER_US;
  localparam logic [19:0] ACTIVE_CYC = 20'(ACTIVE_TIME_US * CYC_PER_US);
  localparam logic [8:0]  DATA_READY_FLAG_GAP_CYC = 9'(DATA_READY_FLAG_GAP_US * CYC_PER_US);
  localparam int RATE_CONVS     = 3;

  // i2c address upper bits and bus select level
  localparam logic [4:0] I2C_ADDR_HI = 5'h03;
  localparam logic       BUS_SPI     = 1'b0;

  // component select bits, scanned upward: Z, Y, X, then temperature
  localparam int CSEL_Z = 0;
  localparam int CSEL_Y = 1;
  localparam int CSEL_X = 2;
  localparam int CSEL_T = 3;

  // synchronised pin vector positions
  localparam int PIN_BSEL = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SDA  = 2;
  localparam int PIN_TRIG = 3;
  localparam int PIN_A0   = 4;
  localparam int PIN_A1   = 5;
  localparam int PIN_W    = 6;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_BURST  = 2'b01,
    MODE_WOC    = 2'b10
  } mms_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_STANDBY_STATE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_CONV   = 3'b011,
    ST_DONE   = 3'b100
  } mms_state_t;

endpackage

/* File: pkg/mms_woc_if.sv */
// mms_woc_if: sequencer to wake-on-change comparator signals.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mms_woc_if;
  logic        clear;
  logic        clear_refs;
  logic        strobe;
  logic [1:0]  comp;
  logic [15:0] sample;
  logic [15:0] threshold;
  logic        use_prev;
  logic        exceeded;

  modport seq (output clear, clear_refs, strobe, comp, sample,
               threshold, use_prev, input exceeded);
  modport cmp (input clear, clear_refs, strobe, comp, sample,
               threshold, use_prev, output exceeded);
endinterface
`default_nettype wire

/* File: src/mms_woc_cmp.sv */
// mms_woc_cmp: per-component reference store and threshold compare.
// assumes strobes arrive once per converted component, same clock.
`timescale 1ns/1ps
`default_nettype none
module mms_woc_cmp
  import mms_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // sequencer side
  mms_woc_if.cmp    woc
);

  logic [3:0][15:0] ref_val;
  logic [3:0]       ref_ok;
  logic             hit;

  // samples are two's complement; result is one bit wider
  function automatic logic [16:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    logic signed [16:0] d;
    d = $signed({a[15], a}) - $signed({b[15], b});
    abs_diff = d[16] ? 17'(-d) : 17'(d);
  endfunction

  always_comb
  begin
    hit = ref_ok[woc.comp]
          && (abs_diff(woc.sample, ref_val[woc.comp])
              > {1'b0, woc.threshold});
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst || woc.clear_refs)
      ref_ok <= 4'h0;
    else if (woc.strobe && (!ref_ok[woc.comp] || woc.use_prev))
      ref_ok[woc.comp] <= 1'b1;
  end

  // fixed reference loads once; previous-sample reloads every time
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      ref_val <= '0;
    else if (woc.strobe && (!ref_ok[woc.comp] || woc.use_prev))
      ref_val[woc.comp] <= woc.sample;
  end

  // any component over threshold flags the whole set
  always_ff @(posedge i_clock)
  begin
    if (i_rst || woc.clear_refs)
      woc.exceeded <= 1'b0;
    else if (woc.strobe && hit)
      woc.exceeded <= 1'b1;
    else if (woc.clear)
      woc.exceeded <= 1'b0;
  end

endmodule
`default_nettype wire

/* File: src/mms_seq.sv */
// mms_seq: mode sequencer, pin steering and data-ready of a
// three-axis magnetometer.
// assumes protocol engines and the converter share i_clock and
// deliver one-cycle command pulses; pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module mms_seq
  import mms_pkg::*;
#(
  parameter logic [19:0] STANDBY_STATE_CYCLES = 20'(STANDBY_STATE_CYC),
  parameter logic [15:0] TICK_CYCLES = 16'(TICK_CYC)
)
(
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // device pins
  input  wire logic             i_bus_select_pin,
  input  wire logic             i_sclk_pin,
  input  wire logic             i_sda_pin,
  input  wire logic             i_trigger_pin,
  input  wire logic             i_address_pin_low,
  input  wire logic             i_address_pin_high,
  output var  logic             o_sda_out,
  output var  logic             o_sda_oe,
  output var  logic             o_miso,
  output var  logic             o_trigger_out,
  output var  logic             o_trigger_oe,
  output var  logic             o_data_ready,
  // protocol engine side
  output var  logic             o_bus_is_i2c,
  output var  logic [6:0]       o_i2c_addr,
  output var  logic             o_i2c_scl,
  output var  logic             o_i2c_sda,
  output var  logic             o_spi_sck,
  output var  logic             o_spi_mosi,
  input  wire logic             i_i2c_sda_pull,
  input  wire logic             i_spi_miso_data,
  // commands, one-cycle pulses
  input  wire logic             i_cmd_single,
  input  wire logic             i_cmd_burst,
  input  wire logic             i_cmd_woc,
  input  wire logic             i_cmd_exit,
  input  wire logic             i_cmd_reset,
  input  wire logic             i_cmd_read,
  // configuration
  input  wire logic [3:0]       i_component_select_field,
  input  wire logic [19:0]      i_conv_cycles,
  input  wire logic [12:0]      i_interval_ms,
  input  wire logic [3:0][15:0] i_thresholds,
  input  wire logic             i_woc_use_prev,
  input  wire logic             i_trigger_is_output,
  // converter side
  output var  logic             o_conv_start,
  output var  logic [1:0]       o_conv_comp,
  input  wire logic [15:0]      i_conv_data,
  // status
  output var  logic [1:0]       o_mode,
  output var  logic             o_busy
);

  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_lvl;
  logic             trig_prev;
  logic             trig_edge;
  logic             bus_i2c;

  mms_mode_t        mode;
  mms_state_t       state;
  logic [19:0]      timer;
  logic [1:0]       comp_idx;
  logic             wait_ivl;
  logic [23:0]      set_cnt;
  logic [15:0]      tick_cnt;
  logic [12:0]      ms_cnt;
  logic             data_ready_flag_flag;
  logic [8:0]       gap_cnt;

  logic             kill;
  logic             req_single;
  logic             go_periodic;
  logic             conv_end;
  logic             set_ready;
  logic             ivl_done;
  logic [2:0]       first_comp;
  logic [2:0]       next_comp;

  mms_woc_if woc ();

  mms_woc_cmp u_woc_cmp (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .woc     (woc.cmp)
  );

  // first selected component at or above start, {found, index}
  function automatic logic [2:0] find_comp(input logic [3:0] sel,
                                           input logic [2:0] start);
    find_comp = 3'b000;
    for (int i = 3; i >= 0; i--)
    begin
      if (sel[i] && (3'(i) >= start))
        find_comp = {1'b1, 2'(i)};
    end
  endfunction

  // shortest set period allowed for the programmed conversion time
  function automatic logic [23:0] min_period(input logic [19:0] c);
    min_period = 24'(c) * 24'(RATE_CONVS);
  endfunction

  // pins: three stages, a change counts once stages two and three agree
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end
    else
    begin
      pin_s1 <= {i_address_pin_high, i_address_pin_low, i_trigger_pin,
                 i_sda_pin, i_sclk_pin, i_bus_select_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      pin_lvl <= '0;
    else
    begin
      for (int i = 0; i < PIN_W; i++)
      begin
        if (pin_s2[i] == pin_s3[i])
          pin_lvl[i] <= pin_s2[i];
      end
    end
  end

  assign bus_i2c = (pin_lvl[PIN_BSEL] != BUS_SPI);

  // steering to the engines; idle bus levels when deselected
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_bus_is_i2c <= 1'b0;
      o_i2c_scl    <= 1'b1;
      o_i2c_sda    <= 1'b1;
      o_spi_sck    <= 1'b1;
      o_spi_mosi   <= 1'b0;
      o_sda_out    <= 1'b0;
      o_sda_oe     <= 1'b0;
      o_miso       <= 1'b0;
      o_i2c_addr   <= {I2C_ADDR_HI, 2'b00};
    end
    else
    begin
      o_bus_is_i2c <= bus_i2c;
      o_i2c_scl    <= bus_i2c ? pin_lvl[PIN_SCLK] : 1'b1;
      o_i2c_sda    <= bus_i2c ? pin_lvl[PIN_SDA] : 1'b1;
      o_spi_sck    <= bus_i2c ? 1'b1 : pin_lvl[PIN_SCLK];
      o_spi_mosi   <= bus_i2c ? 1'b0 : pin_lvl[PIN_SDA];
      // open drain: only ever pulls low, never in spi
      o_sda_out    <= 1'b0;
      o_sda_oe     <= bus_i2c && i_i2c_sda_pull;
      o_miso       <= bus_i2c ? 1'b0 : i_spi_miso_data;
      o_i2c_addr   <= {I2C_ADDR_HI, pin_lvl[PIN_A1],
                       pin_lvl[PIN_A0]};
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      trig_prev <= 1'b0;
    else
      trig_prev <= pin_lvl[PIN_TRIG];
  end

  assign trig_edge = pin_lvl[PIN_TRIG] && !trig_prev
                     && !i_trigger_is_output;
  assign req_single = i_cmd_single || trig_edge;
  assign kill = i_cmd_exit || i_cmd_reset;
  assign go_periodic = i_cmd_burst || i_cmd_woc;
  assign conv_end = (state == ST_CONV) && (timer <= 20'h00001);
  assign first_comp = find_comp(i_component_select_field, 3'b000);
  assign next_comp = find_comp(i_component_select_field,
                               3'({1'b0, comp_idx} + 3'h1));
  assign ivl_done = (ms_cnt >= i_interval_ms)
                    && (set_cnt >= min_period(i_conv_cycles));
  assign set_ready = (state == ST_DONE)
                     && ((mode != MODE_WOC) || woc.exceeded);

  // operating mode
  always_ff @(posedge i_clock)
  begin
    if (i_rst || kill)
      mode <= MODE_SINGLE;
    else if (i_cmd_woc)
      mode <= MODE_WOC;
    else if (i_cmd_burst)
      mode <= MODE_BURST;
    else if (i_cmd_single && (mode != MODE_SINGLE))
      mode <= MODE_SINGLE;
  end

  // acquisition sequence
  always_ff @(posedge i_clock)
  begin
    if (i_rst || kill)
    begin
      state    <= ST_IDLE;
      timer    <= 20'h00000;
      comp_idx <= 2'b00;
      wait_ivl <= 1'b0;
    end
    else if (i_cmd_single && (mode != MODE_SINGLE))
    begin
      // leaving periodic operation drops the current set
      state    <= ST_IDLE;
      wait_ivl <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (req_single || go_periodic)
          begin
            state    <= ST_STANDBY_STATE;
            timer    <= STANDBY_STATE_CYCLES;
            wait_ivl <= 1'b0;
          end
        end
        ST_STANDBY_STATE:
        begin
          if (wait_ivl ? ivl_done : (timer <= 20'h00001))
          begin
            state <= ST_ACTIVE;
            timer <= ACTIVE_CYC;
          end
          else if (!wait_ivl)
            timer <= timer - 20'h00001;
        end
        ST_ACTIVE:
        begin
          if (timer <= 20'h00001)
          begin
            state    <= first_comp[2] ? ST_CONV : ST_DONE;
            comp_idx <= first_comp[1:0];
            timer    <= i_conv_cycles;
          end
          else
            timer <= timer - 20'h00001;
        end
        ST_CONV:
        begin
          if (conv_end)
          begin
            state    <= next_comp[2] ? ST_CONV : ST_DONE;
            comp_idx <= next_comp[1:0];
            timer    <= i_conv_cycles;
          end
          else
            timer <= timer - 20'h00001;
        end
        ST_DONE:
        begin
          // periodic modes keep their counter running in standby
          state    <= (mode == MODE_SINGLE) ? ST_IDLE : ST_STANDBY_STATE;
          wait_ivl <= (mode != MODE_SINGLE);
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // interval runs from the end of one set to the start of the next
  always_ff @(posedge i_clock)
  begin
    if (i_rst || !(state == ST_STANDBY_STATE && wait_ivl))
    begin
      tick_cnt <= 16'h0000;
      ms_cnt   <= 13'h0000;
    end
    else if (tick_cnt >= TICK_CYCLES - 16'h0001)
    begin
      tick_cnt <= 16'h0000;
      if (ms_cnt != 13'h1fff)
        ms_cnt <= ms_cnt + 13'h0001;
    end
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  // set period counter, from the start of active to the next start
  always_ff @(posedge i_clock)
  begin
    if (i_rst || (state == ST_IDLE)
        || (state == ST_STANDBY_STATE && !wait_ivl))
      set_cnt <= 24'h000000;
    else if (state == ST_STANDBY_STATE && ivl_done)
      set_cnt <= 24'h000000;
    else if (set_cnt != 24'hffffff)
      set_cnt <= set_cnt + 24'h000001;
  end

  // data-ready flag: a new set wins over a read in the same cycle
  always_ff @(posedge i_clock)
  begin
    if (i_rst || kill)
      data_ready_flag_flag <= 1'b0;
    else if (set_ready)
      data_ready_flag_flag <= 1'b1;
    else if (i_cmd_read)
      data_ready_flag_flag <= 1'b0;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst || kill)
      gap_cnt <= 9'h000;
    else if (set_ready && data_ready_flag_flag && (mode != MODE_SINGLE))
      gap_cnt <= DATA_READY_FLAG_GAP_CYC;
    else if (gap_cnt != 9'h000)
      gap_cnt <= gap_cnt - 9'h001;
  end

  // outputs: data-ready pin and optional copy on the trigger pin
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_data_ready  <= 1'b0;
      o_trigger_out <= 1'b0;
      o_trigger_oe  <= 1'b0;
    end
    else
    begin
      o_data_ready  <= data_ready_flag_flag && (gap_cnt == 9'h000);
      o_trigger_out <= data_ready_flag_flag && (gap_cnt == 9'h000)
                       && i_trigger_is_output;
      o_trigger_oe  <= i_trigger_is_output;
    end
  end

  // converter handshake, one start pulse per component
  always_ff @(posedge i_clock)
  begin
    if (i_rst || kill)
    begin
      o_conv_start <= 1'b0;
      o_conv_comp  <= 2'b00;
    end
    else if (state == ST_ACTIVE && timer <= 20'h00001)
    begin
      o_conv_start <= first_comp[2];
      o_conv_comp  <= first_comp[1:0];
    end
    else if (conv_end)
    begin
      o_conv_start <= next_comp[2];
      o_conv_comp  <= next_comp[1:0];
    end
    else
      o_conv_start <= 1'b0;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_mode <= MODE_SINGLE;
      o_busy <= 1'b0;
    end
    else
    begin
      o_mode <= mode;
      o_busy <= (state != ST_IDLE);
    end
  end

  // comparator feed; sample taken on the last cycle of a conversion
  assign woc.clear      = (state == ST_ACTIVE);
  assign woc.clear_refs = i_cmd_reset
                          || (i_cmd_woc && mode != MODE_WOC);
  assign woc.strobe     = conv_end && (mode == MODE_WOC);
  assign woc.comp       = comp_idx;
  assign woc.sample     = i_conv_data;
  assign woc.threshold  = i_thresholds[comp_idx];
  assign woc.use_prev   = i_woc_use_prev;

endmodule
`default_nettype wire

/* File: bench/mms_seq_checker.sv */
// mms_seq_checker: port-level assertions on the mode sequencer.
// assumes bind onto mms_seq; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mms_seq_checker
  import mms_pkg::*;
#(
  parameter logic [19:0] STANDBY_STATE_CYCLES = 20'(STANDBY_STATE_CYC)
)
(
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // pins, commands and configuration
  input wire logic        i_bus_select_pin,
  input wire logic        i_sclk_pin,
  input wire logic        i_address_pin_low,
  input wire logic        i_address_pin_high,
  input wire logic        i_cmd_exit,
  input wire logic        i_cmd_reset,
  input wire logic        i_cmd_read,
  input wire logic        i_cmd_woc,
  input wire logic [3:0]  i_component_select_field,
  input wire logic [19:0] i_conv_cycles,
  // outputs watched
  input wire logic [6:0]  o_i2c_addr,
  input wire logic        o_bus_is_i2c,
  input wire logic        o_i2c_scl,
  input wire logic        o_spi_sck,
  input wire logic        o_data_ready,
  input wire logic        o_conv_start,
  input wire logic [1:0]  o_conv_comp,
  input wire logic [1:0]  o_mode,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [19:0] gap;
  logic [19:0] busy_cyc;
  logic [1:0]  last_comp;
  logic [8:0]  low_cnt;
  logic        rd_seen;
  logic        dr_q;
  logic [19:0] conv;
  assign conv = (i_conv_cycles == 20'h0) ? 20'h1 : i_conv_cycles;
  // saturate so a long idle never wraps into a false spacing
  always_ff @(posedge i_clock)
    if (i_rst || o_conv_start) gap <= i_rst ? 20'hfffff : 20'h1;
    else if (gap != 20'hfffff) gap <= gap + 20'h1;
  always_ff @(posedge i_clock)
    if (o_conv_start) last_comp <= o_conv_comp;
  always_ff @(posedge i_clock)
    busy_cyc <= o_busy ? busy_cyc + 20'h1 : 20'h0;
  always_ff @(posedge i_clock)
    if (i_rst || o_data_ready) low_cnt <= 9'h0;
    else if (low_cnt != 9'h1ff) low_cnt <= low_cnt + 9'h1;
  always_ff @(posedge i_clock)
    dr_q <= o_data_ready;
  // a read or cancel since the last rise lets data-ready return early
  always_ff @(posedge i_clock)
    if (i_rst || i_cmd_read || i_cmd_exit || i_cmd_reset) rd_seen <= 1'b1;
    else if (o_data_ready && !dr_q) rd_seen <= 1'b0;
  sequence s_pins_still;
    ($stable(i_bus_select_pin) && $stable(i_sclk_pin) &&
     $stable(i_address_pin_low) && $stable(i_address_pin_high))[*8];
  endsequence
  property p_bus_sel;
    s_pins_still |-> o_bus_is_i2c == i_bus_select_pin;
  endproperty
  a_bus_sel: assert property (p_bus_sel) else $error("bus select");
  property p_steer;
    s_pins_still |-> o_i2c_scl == (i_bus_select_pin ? i_sclk_pin : 1'b1)
      && o_spi_sck == (i_bus_select_pin ? 1'b1 : i_sclk_pin);
  endproperty
  a_steer: assert property (p_steer) else $error("clock steering");
  property p_addr;
    s_pins_still |->
      o_i2c_addr == {I2C_ADDR_HI, i_address_pin_high, i_address_pin_low};
  endproperty
  a_addr: assert property (p_addr) else $error("address bits");
  property p_boot;
    $fell(i_rst) |-> !o_busy && !o_data_ready && o_mode == MODE_SINGLE;
  endproperty
  a_boot: assert property (p_boot) else $error("start state");
  property p_cancel;
    i_cmd_exit || i_cmd_reset |-> ##2 !o_data_ready && o_mode == MODE_SINGLE;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel");
  property p_read;
    i_cmd_read && !o_busy |-> ##2 !o_data_ready;
  endproperty
  a_read: assert property (p_read) else $error("read clear");
  property p_woc;
    i_cmd_woc |-> ##[1:2] o_mode == MODE_WOC;
  endproperty
  a_woc: assert property (p_woc) else $error("mode change");
  property p_order;
    o_conv_start && gap <= conv |-> o_conv_comp > last_comp;
  endproperty
  a_order: assert property (p_order) else $error("component order");
  property p_sel;
    o_conv_start |-> i_component_select_field[o_conv_comp];
  endproperty
  a_sel: assert property (p_sel) else $error("unselected component");
  property p_space;
    o_conv_start |-> gap >= conv;
  endproperty
  a_space: assert property (p_space) else $error("axis spacing");
  property p_standby_state;
    o_conv_start && o_mode == MODE_SINGLE |->
      busy_cyc >= STANDBY_STATE_CYCLES + ACTIVE_CYC - 20'h2;
  endproperty
  a_standby_state: assert property (p_standby_state) else $error("phases skipped");
  property p_gap;
    $rose(o_data_ready) && o_mode != MODE_SINGLE && !rd_seen |->
      low_cnt >= DATA_READY_FLAG_GAP_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("ready gap");
endmodule
bind mms_seq mms_seq_checker #(.STANDBY_STATE_CYCLES(STANDBY_STATE_CYCLES)) chk_u (.*);
`default_nettype wire

/* File: bench/mms_conv_model.sv */
// mms_conv_model: converter stand-in giving a base plus axis offset.
// assumes data is sampled at the end of each conversion period.
`timescale 1ns/1ps
`default_nettype none
module mms_conv_model (
  // clock
  input  wire logic        i_clock,
  // sequencer side and bench base value
  input  wire logic        i_conv_start,
  input  wire logic [1:0]  i_conv_comp,
  input  wire logic [15:0] i_base,
  output var  logic [15:0] o_data
);
  logic [1:0] comp;
  always_ff @(posedge i_clock)
    if (i_conv_start) comp <= i_conv_comp;
  // axis offset keeps components distinguishable
  assign o_data = i_base + {14'h0, comp};
endmodule
`default_nettype wire

/* File: bench/tb_magnetometer_mode_sequencer.sv */
// tb_magnetometer_mode_sequencer: command-level test of mms_seq.
// assumes short standby and tick parameters; 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_magnetometer_mode_sequencer;
  import mms_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, i_bus_select_pin = 1'b1;
  logic i_sclk_pin = 1'b1, i_sda_pin = 1'b0, i_trigger_pin = 1'b0;
  logic i_address_pin_low = 1'b1, i_address_pin_high = 1'b0;
  logic i_i2c_sda_pull = 1'b1, i_spi_miso_data = 1'b1;
  logic i_woc_use_prev = 1'b0, i_trigger_is_output = 1'b0;
  logic [5:0] cmds = 6'h0;
  logic [3:0] i_component_select_field = 4'hb;
  logic [19:0] i_conv_cycles = 20'h4;
  logic [12:0] i_interval_ms = 13'ha;
  logic [3:0][15:0] i_thresholds = {4{16'h0010}};
  logic [15:0] i_conv_data, base = 16'h0100;
  logic o_sda_out, o_sda_oe, o_miso, o_trigger_out, o_trigger_oe;
  logic o_data_ready, o_bus_is_i2c, o_i2c_scl, o_i2c_sda, o_spi_sck;
  logic o_spi_mosi, o_conv_start, o_busy;
  logic [6:0] o_i2c_addr;
  logic [1:0] o_conv_comp, o_mode;
  logic [1:0] comps[$];
  int failures = 0, checked = 0, cyc = 0, n, low;
  mms_seq #(.STANDBY_STATE_CYCLES(20'd20), .TICK_CYCLES(16'd10)) dut_u (.*,
    .i_cmd_single(cmds[0]), .i_cmd_burst(cmds[1]), .i_cmd_woc(cmds[2]),
    .i_cmd_exit(cmds[3]), .i_cmd_reset(cmds[4]), .i_cmd_read(cmds[5]));
  mms_conv_model conv_u (.i_clock(i_clock), .i_conv_start(o_conv_start),
    .i_conv_comp(o_conv_comp), .i_base(base), .o_data(i_conv_data));
  always #12.5 i_clock = ~i_clock;
  always @(posedge i_clock)
    if (o_conv_start === 1'b1) comps.push_back(o_conv_comp);
  task automatic summarize;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // 0 single 1 burst 2 woc 3 exit 4 reset 5 read
  task automatic cmd(input int k);
    @(posedge i_clock);
    cmds <= 6'h1 << k;
    @(posedge i_clock);
    cmds <= 6'h0;
    repeat (2) @(negedge i_clock);
  endtask
  task automatic wait_dr(input int lim, output int c);
    c = 0;
    while (o_data_ready !== 1'b1 && c < lim)
    begin
      @(negedge i_clock);
      c++;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (8) @(negedge i_clock);
    chk("mode", o_mode, MODE_SINGLE);
    chk("busy", o_busy, 1'b0);
    chk("pins", {o_bus_is_i2c, o_spi_sck, o_i2c_scl, o_sda_oe, o_i2c_sda,
                 o_spi_mosi, o_sda_out}, 7'h78);
    chk("addr", o_i2c_addr, {I2C_ADDR_HI, 2'b01});
    @(posedge i_clock);
    i_bus_select_pin <= 1'b0;
    i_address_pin_high <= 1'b1;
    i_address_pin_low <= 1'b0;
    i_sclk_pin <= 1'b0;
    i_sda_pin <= 1'b1;
    repeat (6) @(negedge i_clock);
    chk("pins", {o_bus_is_i2c, o_spi_sck, o_i2c_scl, o_miso, o_spi_mosi,
                 o_i2c_sda, o_sda_oe}, 7'h1e);
    chk("addr", o_i2c_addr, {I2C_ADDR_HI, 2'b10});
    wait_dr(400, n);
    chk("idle ready", o_data_ready, 1'b0);
    cmd(0);
    wait_dr(2000, n);
    chk("ready", o_data_ready, 1'b1);
    chk("phases", 16'(n >= 340), 16'h1);
    chk("order", {comps[0], comps[1], comps[2]}, 6'b000111);
    repeat (400) @(negedge i_clock);
    chk("one set", 16'(comps.size()), 16'h3);
    chk("busy", o_busy, 1'b0);
    cmd(5);
    chk("read", o_data_ready, 1'b0);
    @(posedge i_clock);
    i_trigger_pin <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_trigger_pin <= 1'b0;
    wait_dr(2000, n);
    chk("trigger", o_data_ready, 1'b1);
    cmd(3);
    chk("exit", o_data_ready, 1'b0);
    @(posedge i_clock);
    i_trigger_is_output <= 1'b1;
    cmd(0);
    wait_dr(2000, n);
    chk("trig out", {o_trigger_oe, o_trigger_out}, 2'b11);
    cmd(4);
    chk("reset cmd", o_data_ready, 1'b0);
    @(posedge i_clock);
    i_trigger_is_output <= 1'b0;
    i_component_select_field <= 4'h7;
    comps.delete();
    cmd(1);
    chk("burst", o_mode, MODE_BURST);
    wait_dr(2000, n);
    chk("first set", 16'(comps.size()), 16'h3);
    while (o_data_ready === 1'b1 && n < 4000)
    begin
      @(negedge i_clock);
      n++;
    end
    low = 0;
    while (o_data_ready !== 1'b1 && low < 1000)
    begin
      @(negedge i_clock);
      low++;
    end
    chk("gap", 16'(low), 16'(DATA_READY_FLAG_GAP_CYC));
    chk("order", {comps[3], comps[4], comps[5]}, 6'b000110);
    cmd(5);
    chk("burst read", o_data_ready, 1'b0);
    wait_dr(2000, n);
    chk("next set", o_data_ready, 1'b1);
    // rise to rise: interval, active phase and three conversions
    low = cyc;
    cmd(5);
    wait_dr(2000, n);
    n = cyc - low;
    chk("period", 16'(n >= 432 && n <= 436), 16'h1);
    cmd(3);
    @(posedge i_clock);
    i_component_select_field <= 4'h1;
    for (int p = 0; p < 2; p++)
    begin
      @(posedge i_clock);
      i_woc_use_prev <= p[0];
      cmd(2);
      repeat (1500) @(negedge i_clock);
      cmd(5);
      wait_dr(1500, n);
      chk("no change", o_data_ready, 1'b0);
      @(posedge i_clock);
      base <= base ^ 16'h0020;
      wait_dr(1500, n);
      chk("change", o_data_ready, 1'b1);
      cmd(5);
      wait_dr(1500, n);
      chk("reference", o_data_ready, !p[0]);
      cmd(3);
    end
    summarize();
  end
endmodule
`default_nettype wire
